// File: common/lcdhp_defines.svh
/*
  Constants of the LCD driver host bus port: register offsets, field
  positions, reset values, timing and column drive level codes.
  Assumes it is included by bare name after the package.
*/
`ifndef LCDHP_DEFINES_SVH
`define LCDHP_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave
`define LCDHP_OFS_CTRL     8'h00
`define LCDHP_OFS_STATUS   8'h04
`define LCDHP_OFS_CMD      8'h08
`define LCDHP_OFS_WDATA    8'h0C
`define LCDHP_OFS_RNEXT    8'h10
`define LCDHP_OFS_LINE     8'h14
`define LCDHP_OFS_COL_BASE 8'h20

// Control register fields
`define LCDHP_CTRL_BUSY    0
`define LCDHP_CTRL_ADC     1
`define LCDHP_CTRL_OFF     2
`define LCDHP_CTRL_LINE_LO 8

// Status register fields
`define LCDHP_ST_CMD       0
`define LCDHP_ST_WR        1
`define LCDHP_ST_RDREQ     2
`define LCDHP_ST_REJ       3
`define LCDHP_ST_RESET     4
`define LCDHP_ST_MODE68    5
`define LCDHP_ST_BUSY      6

// Reset values
`define LCDHP_RST_ADC      1'h1
`define LCDHP_RST_OFF      1'h1
`define LCDHP_RST_LINE     5'h00

// Initialisation time after an edge on the init/bus-select pin
`define LCDHP_CLK_NS       50
`define LCDHP_INIT_NS      2000
`define LCDHP_INIT_CYC \
  ((`LCDHP_INIT_NS + `LCDHP_CLK_NS - 1) / `LCDHP_CLK_NS)

// Column drive level codes
`define LCDHP_LVL_VSS      2'h0
`define LCDHP_LVL_VC2      2'h1
`define LCDHP_LVL_VC3      2'h2
`define LCDHP_LVL_VC5      2'h3

`endif

// File: common/lcdhp_pkg.sv
/*
  Types of the LCD driver host bus port.
  Assumes nothing of its surroundings.
*/
package lcdhp_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_RD,
    PH_WR
  } lcdhp_phase_t;

endpackage

// File: logic/lcdhp_column_drive.sv
/*
  Column drive stage: latches one display line on each line advance
  and selects one of four drive levels per column from data and phase.
  Assumes adv_en is a one-cycle pulse and ac_phase is already synchronised.
*/
`timescale 1ns/1ps
`include "lcdhp_defines.svh"

module lcdhp_column_drive #(
  parameter int NCOL = 80
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Line data and timing
  input  wire logic              adv_en,
  input  wire logic              ac_phase,
  input  wire logic [NCOL-1:0]   line_data,
  // Drive level codes, two bits per column
  output logic      [2*NCOL-1:0] levels
);

  typedef struct packed {
    logic [NCOL-1:0]   lat;
    logic [2*NCOL-1:0] lvl;
  } lcdhp_col_state_t;

  lcdhp_col_state_t q;
  lcdhp_col_state_t d;
  logic [2*NCOL-1:0] lvl_sel;

  genvar gi;
  generate
    for (gi = 0; gi < NCOL; gi++) begin : g_col
      assign lvl_sel[2*gi +: 2] =
        ac_phase ? (q.lat[gi] ? `LCDHP_LVL_VC5 : `LCDHP_LVL_VC2)
                 : (q.lat[gi] ? `LCDHP_LVL_VSS : `LCDHP_LVL_VC3);
    end
  endgenerate

  always_comb begin
    d = q;
    if (adv_en) begin
      d.lat = line_data;
    end
    d.lvl = lvl_sel;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign levels = q.lvl;

endmodule

// File: logic/lcdhp_host_port.sv
/*
  Host bus port of a dot-matrix LCD column driver: 8-bit parallel host
  port in 68- or 80-style protocol, status byte, pipelined display read
  latch, line timing and an Avalon-MM slave for the internal side.
  Assumes all pins are asynchronous to mclk and strobes last several
  mclk periods; the internal side services commands through the slave.
*/
// Added by the designer: the Avalon-MM register port and the register addresses.
// Notes on behaviour
// - Eight-bit data bus driven only during host reads, released otherwise.
// - Select low means control byte, high means display memory data.
// - Init pin level picks protocol: high 68-style, low 80-style.
// - Chip select high ignores strobes and releases the bus.
// - 80-style: bus driven while read strobe low and chip selected.
// - 80-style: write byte captured at rising edge of write strobe.
// - 68-style: shared strobe pin is an active-high enable.
// - 68-style: read/write pin high reads, low writes.
// - Select and direction decode to data read/write, status, command.
// - Data read returns latch, latch loads next byte: one read lag.
// - Writes take effect directly, no dummy cycle needed.
// - While busy, everything except status read is rejected.
// - Busy flag appears on data bit seven in status reads.
// - Both edges of line clock latch data and advance counters.
// - Frame phase input is the drive polarity reference.
// - Each column picks one of four levels from data and phase.
// - Status: busy, direction, display off, resetting; low nibble zero.
`timescale 1ns/1ps
`include "lcdhp_defines.svh"

module lcdhp_host_port #(
  parameter int NCOL = 80
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Host bus pins
  input  wire logic              cs_n,
  input  wire logic              data_command_select,
  input  wire logic              enable_or_rd_n,
  input  wire logic              rw_or_wr_n,
  input  wire logic              init_and_bus_select,
  input  wire logic [7:0]        db_in,
  output logic      [7:0]        db_out,
  output logic                   db_oe_n,
  // Display timing pins
  input  wire logic              row_advance_strobe,
  input  wire logic              lcd_ac_phase,
  output logic      [2*NCOL-1:0] column_drive_outputs,
  // Avalon-MM slave
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest
);

  localparam int COLW = (NCOL + 31) / 32;
  localparam logic [7:0] INIT_CYC = 8'(`LCDHP_INIT_CYC);

  typedef struct packed {
    // Two-stage synchronisers
    logic                   cs_m;
    logic                   cs_s;
    logic                   e_m;
    logic                   e_s;
    logic                   w_m;
    logic                   w_s;
    logic                   dc_m;
    logic                   dc_s;
    logic                   ini_m;
    logic                   ini_s;
    logic                   cl_m;
    logic                   cl_s;
    logic                   fr_m;
    logic                   fr_s;
    logic [7:0]             db_m;
    logic [7:0]             db_s;
    logic                   ini_prev;
    logic                   cl_prev;
    logic                   fr_prev;
    // Host cycle tracking
    lcdhp_pkg::lcdhp_phase_t ph;
    logic                   dc_cyc;
    logic [7:0]             wr_byte;
    logic [7:0]             out_latch;
    logic [7:0]             rd_next;
    logic [7:0]             db_out;
    logic                   drive;
    // Handover to internal side
    logic [7:0]             cmd_byte;
    logic [7:0]             wr_data;
    logic                   cmd_pend;
    logic                   wr_pend;
    logic                   rd_req;
    logic                   rejected;
    // Control and status
    logic                   ctl_busy;
    logic                   adc;
    logic                   disp_off;
    logic [4:0]             start_line;
    logic [7:0]             init_cnt;
    logic                   resetting;
    logic [4:0]             line_cnt;
    logic                   adv;
    logic [COLW*32-1:0]     col_shadow;
    // Bus slave
    logic                   ack;
    logic [31:0]            rdata;
  } lcdhp_state_t;

  lcdhp_state_t q;
  lcdhp_state_t d;

  logic       mode68;
  logic       rd_now;
  logic       wr_now;
  logic       busy;
  logic [7:0] status_byte;
  logic       req;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] col_ofs(input int idx);
    return 8'(`LCDHP_OFS_COL_BASE + 4 * idx);
  endfunction

  assign mode68 = q.ini_s;
  assign busy   = q.ctl_busy || q.resetting;
  assign req    = avs_read || avs_write;

  assign status_byte = {busy, q.adc, q.disp_off, q.resetting, 4'h0};

  always_comb begin
    rd_now = !q.cs_s && (mode68 ? (q.e_s && q.w_s) : !q.e_s);
    wr_now = !q.cs_s && (mode68 ? (q.e_s && !q.w_s) : !q.w_s);
  end

  always_comb begin
    logic [31:0] ctrl_v;
    logic [31:0] rmux;
    ctrl_v = '0;
    rmux   = '0;
    d      = q;

    d.cs_m  = cs_n;
    d.cs_s  = q.cs_m;
    d.e_m   = enable_or_rd_n;
    d.e_s   = q.e_m;
    d.w_m   = rw_or_wr_n;
    d.w_s   = q.w_m;
    d.dc_m  = data_command_select;
    d.dc_s  = q.dc_m;
    d.ini_m = init_and_bus_select;
    d.ini_s = q.ini_m;
    d.cl_m  = row_advance_strobe;
    d.cl_s  = q.cl_m;
    d.fr_m  = lcd_ac_phase;
    d.fr_s  = q.fr_m;
    d.db_m  = db_in;
    d.db_s  = q.db_m;
    d.ini_prev = q.ini_s;
    d.cl_prev  = q.cl_s;
    d.fr_prev  = q.fr_s;
    d.adv      = 1'b0;

    // Avalon slave: one wait cycle, then answer
    ctrl_v[`LCDHP_CTRL_BUSY] = q.ctl_busy;
    ctrl_v[`LCDHP_CTRL_ADC]  = q.adc;
    ctrl_v[`LCDHP_CTRL_OFF]  = q.disp_off;
    ctrl_v[`LCDHP_CTRL_LINE_LO +: 5] = q.start_line;
    case (avs_address)
      `LCDHP_OFS_CTRL: begin
        rmux = ctrl_v;
      end
      `LCDHP_OFS_STATUS: begin
        rmux[`LCDHP_ST_CMD]    = q.cmd_pend;
        rmux[`LCDHP_ST_WR]     = q.wr_pend;
        rmux[`LCDHP_ST_RDREQ]  = q.rd_req;
        rmux[`LCDHP_ST_REJ]    = q.rejected;
        rmux[`LCDHP_ST_RESET]  = q.resetting;
        rmux[`LCDHP_ST_MODE68] = mode68;
        rmux[`LCDHP_ST_BUSY]   = busy;
      end
      `LCDHP_OFS_CMD: begin
        rmux[7:0] = q.cmd_byte;
      end
      `LCDHP_OFS_WDATA: begin
        rmux[7:0] = q.wr_data;
      end
      `LCDHP_OFS_RNEXT: begin
        rmux[7:0] = q.rd_next;
      end
      `LCDHP_OFS_LINE: begin
        rmux[5:0] = {q.fr_s, q.line_cnt};
      end
      default: begin
        for (int i = 0; i < COLW; i++) begin
          if (avs_address == col_ofs(i)) begin
            rmux = q.col_shadow[32*i +: 32];
          end
        end
      end
    endcase

    d.ack = 1'b0;
    if (req && !q.ack) begin
      d.ack   = 1'b1;
      d.rdata = avs_read ? rmux : 32'h0000_0000;
    end
    if (q.ack && avs_write) begin
      case (avs_address)
        `LCDHP_OFS_CTRL: begin
          ctrl_v       = merge(ctrl_v, avs_writedata, avs_byteenable);
          d.ctl_busy   = ctrl_v[`LCDHP_CTRL_BUSY];
          d.adc        = ctrl_v[`LCDHP_CTRL_ADC];
          d.disp_off   = ctrl_v[`LCDHP_CTRL_OFF];
          d.start_line = ctrl_v[`LCDHP_CTRL_LINE_LO +: 5];
        end
        `LCDHP_OFS_RNEXT: begin
          if (avs_byteenable[0]) begin
            d.rd_next = avs_writedata[7:0];
          end
          d.rd_req = 1'b0;
        end
        default: begin
          for (int i = 0; i < COLW; i++) begin
            if (avs_address == col_ofs(i)) begin
              d.col_shadow[32*i +: 32] = merge(q.col_shadow[32*i +: 32],
                                               avs_writedata,
                                               avs_byteenable);
            end
          end
        end
      endcase
    end
    if (q.ack && avs_read) begin
      case (avs_address)
        `LCDHP_OFS_STATUS: d.rejected = 1'b0;
        `LCDHP_OFS_CMD:    d.cmd_pend = 1'b0;
        `LCDHP_OFS_WDATA:  d.wr_pend  = 1'b0;
        default: begin
        end
      endcase
    end

    if (q.ini_s != q.ini_prev) begin
      d.init_cnt   = INIT_CYC;
      d.resetting  = 1'b1;
      d.disp_off   = `LCDHP_RST_OFF;
      d.adc        = `LCDHP_RST_ADC;
      d.start_line = `LCDHP_RST_LINE;
    end else if (q.resetting) begin
      d.init_cnt = q.init_cnt - 8'h01;
      if (q.init_cnt <= 8'h01) begin
        d.resetting = 1'b0;
      end
    end

    // Host cycles; bus events set after slave clears, so sets win
    case (q.ph)
      lcdhp_pkg::PH_IDLE: begin
        if (rd_now) begin
          d.ph     = lcdhp_pkg::PH_RD;
          d.dc_cyc = q.dc_s;
          d.db_out = q.dc_s ? q.out_latch : status_byte;
          d.drive  = 1'b1;
        end else if (wr_now) begin
          d.ph      = lcdhp_pkg::PH_WR;
          d.dc_cyc  = q.dc_s;
          d.wr_byte = q.db_s;
        end
      end
      lcdhp_pkg::PH_RD: begin
        if (!rd_now) begin
          d.ph    = lcdhp_pkg::PH_IDLE;
          d.drive = 1'b0;
          if (q.dc_cyc) begin
            if (busy) begin
              d.rejected = 1'b1;
            end else begin
              d.out_latch = q.rd_next;
              d.rd_req    = 1'b1;
            end
          end
        end
      end
      lcdhp_pkg::PH_WR: begin
        if (wr_now) begin
          d.wr_byte = q.db_s;
        end else begin
          d.ph = lcdhp_pkg::PH_IDLE;
          if (busy) begin
            d.rejected = 1'b1;
          end else if (q.dc_cyc) begin
            d.wr_data = q.wr_byte;
            d.wr_pend = 1'b1;
          end else begin
            d.cmd_byte = q.wr_byte;
            d.cmd_pend = 1'b1;
          end
        end
      end
      default: begin
        d.ph    = lcdhp_pkg::PH_IDLE;
        d.drive = 1'b0;
      end
    endcase

    if (q.cl_s != q.cl_prev) begin
      d.line_cnt = q.line_cnt + 5'h01;
      d.adv      = 1'b1;
    end
    if (q.fr_s != q.fr_prev) begin
      d.line_cnt = q.start_line;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q            <= '0;
      q.cs_m       <= 1'b1;
      q.cs_s       <= 1'b1;
      q.e_m        <= 1'b1;
      q.e_s        <= 1'b1;
      q.w_m        <= 1'b1;
      q.w_s        <= 1'b1;
      q.ph         <= lcdhp_pkg::PH_IDLE;
      q.adc        <= `LCDHP_RST_ADC;
      q.disp_off   <= `LCDHP_RST_OFF;
      q.start_line <= `LCDHP_RST_LINE;
    end else begin
      q <= d;
    end
  end

  lcdhp_column_drive #(
    .NCOL (NCOL)
  ) u_cols (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .adv_en    (q.adv),
    .ac_phase  (q.fr_s),
    .line_data (q.disp_off ? '0 : q.col_shadow[NCOL-1:0]),
    .levels    (column_drive_outputs)
  );

  assign db_out          = q.db_out;
  assign db_oe_n         = !q.drive;
  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = req && !q.ack;

endmodule

// File: bench/lcdhp_host_monitor.sv
/*
  Checker of the LCD host bus port: bus release, read drive, Avalon
  wait state and column polarity.
  Assumes binding to lcdhp_host_port and strobes held several cycles.
*/
`timescale 1ns/1ps
module lcdhp_host_monitor #(
  parameter int NCOL = 80
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // Host and display pins
  input wire logic              cs_n,
  input wire logic              data_command_select,
  input wire logic              enable_or_rd_n,
  input wire logic              rw_or_wr_n,
  input wire logic              init_and_bus_select,
  input wire logic [7:0]        db_out,
  input wire logic              db_oe_n,
  input wire logic              row_advance_strobe,
  input wire logic              lcd_ac_phase,
  input wire logic [2*NCOL-1:0] column_drive_outputs,
  // Avalon-MM slave
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_standby_idle: assert property (cs_n [*6] |-> db_oe_n)
    else $error("bus driven while deselected");
  a_rd80_idle: assert property (
    (!init_and_bus_select && enable_or_rd_n) [*6] |-> db_oe_n)
    else $error("bus driven without read strobe");
  a_rd80_status: assert property (
    (!init_and_bus_select && !cs_n && !enable_or_rd_n
     && !data_command_select) [*5] |-> !db_oe_n && db_out[3:0] == 4'h0)
    else $error("status read not driven");
  a_rd68_status: assert property (
    (init_and_bus_select && !cs_n && enable_or_rd_n && rw_or_wr_n
     && !data_command_select) [*5] |-> !db_oe_n && db_out[3:0] == 4'h0)
    else $error("enable read not driven");
  a_wr68_idle: assert property (
    (init_and_bus_select && !rw_or_wr_n) [*6] |-> db_oe_n)
    else $error("bus driven in write cycle");
  a_avs_one_wait: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state count wrong");
  a_rdata_hold: assert property (
    !(avs_read || avs_write) |=> $stable(avs_readdata))
    else $error("read data changed while idle");
  a_column_phase: assert property (
    $changed(row_advance_strobe) ##1 $stable(lcd_ac_phase) [*8]
    |-> column_drive_outputs[0] == lcd_ac_phase
        && column_drive_outputs[2*NCOL-2] == lcd_ac_phase)
    else $error("column level ignores phase");

  c_rd80: cover property (!db_oe_n && !init_and_bus_select);
  c_rd68: cover property (!db_oe_n && init_and_bus_select);
  c_avs: cover property ($fell(avs_waitrequest));
  c_line: cover property ($changed(row_advance_strobe));
endmodule

bind lcdhp_host_port lcdhp_host_monitor #(.NCOL(NCOL)) i_mon (
  .mclk, .rst_n, .cs_n, .data_command_select, .enable_or_rd_n,
  .rw_or_wr_n, .init_and_bus_select, .db_out, .db_oe_n,
  .row_advance_strobe, .lcd_ac_phase, .column_drive_outputs,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest
);

// File: bench/lcdhp_host_model.sv
/*
  Host processor model: runs 68- or 80-style bus cycles on the pins.
  Assumes the bench picks the mode to match the init pin level.
*/
`timescale 1ns/1ps
module lcdhp_host_model (
  // Clock
  input wire logic       mclk,
  // Bus pins
  output logic           cs_n,
  output logic           dc,
  output logic           en_rd,
  output logic           rw_wr,
  output logic [7:0]     db,
  input wire logic [7:0] db_out,
  input wire logic       db_oe_n
);
  logic m68;

  initial begin
    m68 = 1'b0;
    cs_n = 1'b1;
    dc = 1'b0;
    en_rd = 1'b1;
    rw_wr = 1'b1;
    db = 8'hA5;
  end

  task automatic set_mode(input logic m);
    @(posedge mclk);
    m68 = m;
    en_rd <= !m;
  endtask

  // select per cycle, wide strobe spacing
  task automatic cycle(input logic sel_n, input logic rd, input logic c,
                       input logic [7:0] wd, output logic [7:0] rv,
                       output logic oe_n);
    @(posedge mclk);
    cs_n <= sel_n;
    dc <= c;
    rw_wr <= m68 ? rd : 1'b1;
    db <= rd ? ~db : wd;
    @(posedge mclk);
    if (m68) en_rd <= 1'b1;
    else if (rd) en_rd <= 1'b0;
    else rw_wr <= 1'b0;
    repeat (6) @(posedge mclk);
    // Released bus shows the inverse of the last byte
    rv = db_oe_n ? ~db_out : db_out;
    oe_n = db_oe_n;
    en_rd <= !m68;
    if (!m68) rw_wr <= 1'b1;
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    rw_wr <= 1'b1;
    db <= ~db;
    repeat (2) @(posedge mclk);
  endtask
endmodule

// File: bench/testbench.sv
/*
  Bench of the LCD host bus port: host cycles in both modes, Avalon
  register access, busy refusal, standby and column drive.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`include "lcdhp_defines.svh"
module testbench;
  logic mclk, rst_n, init_and_bus_select, row_advance_strobe, lcd_ac_phase;
  logic avs_read, avs_write, avs_waitrequest, db_oe_n, cs_n, dc, en, rw;
  logic [7:0] avs_address, db, db_out, b, hv;
  logic [31:0] avs_writedata, avs_readdata, rv;
  logic [159:0] column_drive_outputs;
  logic hoe;
  int failures, n_tests, seed;

  lcdhp_host_port #(.NCOL(80)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .data_command_select(dc),
    .enable_or_rd_n(en), .rw_or_wr_n(rw),
    .init_and_bus_select(init_and_bus_select), .db_in(db),
    .db_out(db_out), .db_oe_n(db_oe_n),
    .row_advance_strobe(row_advance_strobe), .lcd_ac_phase(lcd_ac_phase),
    .column_drive_outputs(column_drive_outputs),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  lcdhp_host_model i_host (
    .mclk(mclk), .cs_n(cs_n), .dc(dc), .en_rd(en), .rw_wr(rw), .db(db),
    .db_out(db_out), .db_oe_n(db_oe_n));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t word got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t pin byte got %h exp %h", $time, g, e);
    end
  endtask

  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest) @(posedge mclk);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic hc(input logic s, input logic r, input logic c,
                    input logic [7:0] wd);
    i_host.cycle(s, r, c, wd, hv, hoe);
  endtask

  function automatic logic [1:0] lvl(input logic d, input logic p);
    if (p) lvl = d ? `LCDHP_LVL_VC5 : `LCDHP_LVL_VC2;
    else lvl = d ? `LCDHP_LVL_VSS : `LCDHP_LVL_VC3;
  endfunction

  task automatic suite();
    for (int k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      hc(1'b0, 1'b0, k[0], b);
      av(1'b0, `LCDHP_OFS_STATUS, 32'h0);
      chk(rv & 32'h1F, k[0] ? 32'h2 : 32'h1);
      av(1'b0, k[0] ? `LCDHP_OFS_WDATA : `LCDHP_OFS_CMD, 32'h0);
      chk(rv & 32'hFF, {24'h0, b});
    end
    hc(1'b0, 1'b1, 1'b0, 8'h00);
    chkp(hv, 8'h60);
    chk(hoe, 1'b0);
    av(1'b1, `LCDHP_OFS_RNEXT, {24'h0, b});
    hc(1'b0, 1'b1, 1'b1, 8'h00);
    av(1'b1, `LCDHP_OFS_RNEXT, {24'h0, ~b});
    hc(1'b0, 1'b1, 1'b1, 8'h00);
    chkp(hv, b);
    av(1'b0, `LCDHP_OFS_STATUS, 32'h0);
    chk(rv & 32'h4, 32'h4);
    av(1'b1, `LCDHP_OFS_RNEXT, 32'h0);
    av(1'b0, `LCDHP_OFS_STATUS, 32'h0);
    chk(rv & 32'h4, 32'h0);
  endtask

  task automatic final_report();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    final_report();
  end

  initial begin
    seed = 14104;
    failures = 0;
    n_tests = 0;
    rst_n = 1'b0;
    init_and_bus_select = 1'b0;
    row_advance_strobe = 1'b0;
    lcd_ac_phase = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (50) @(posedge mclk);
    av(1'b0, `LCDHP_OFS_CTRL, 32'h0);
    chk(rv, 32'h6);
    av(1'b1, 8'h3C, 32'hFFFF_FFFF);
    av(1'b0, 8'h3C, 32'h0);
    chk(rv, 32'h0);
    suite();
    // Busy refuses all but status read
    av(1'b1, `LCDHP_OFS_CTRL, 32'h7);
    hc(1'b0, 1'b1, 1'b0, 8'h00);
    chkp(hv, 8'hE0);
    hc(1'b0, 1'b0, 1'b0, 8'h3C);
    av(1'b0, `LCDHP_OFS_STATUS, 32'h0);
    chk(rv & 32'h4B, 32'h48);
    av(1'b1, `LCDHP_OFS_CTRL, 32'h6);
    hc(1'b1, 1'b1, 1'b0, 8'h00);
    chk(hoe, 1'b1);
    hc(1'b1, 1'b0, 1'b0, 8'h5A);
    av(1'b0, `LCDHP_OFS_STATUS, 32'h0);
    chk(rv & 32'hB, 32'h0);
    av(1'b1, `LCDHP_OFS_CTRL, 32'h2);
    for (int k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      av(1'b1, `LCDHP_OFS_COL_BASE, {24'h0, b[7:1], k[0]});
      av(1'b1, `LCDHP_OFS_COL_BASE + 8'h08, {16'h0, k[0], 15'h0});
      @(posedge mclk);
      lcd_ac_phase <= k[1];
      row_advance_strobe <= ~row_advance_strobe;
      repeat (12) @(posedge mclk);
      chk(column_drive_outputs[1:0], lvl(k[0], k[1]));
      chk(column_drive_outputs[159:158], lvl(k[0], k[1]));
    end
    // Init edge selects the enable protocol
    init_and_bus_select <= 1'b1;
    i_host.set_mode(1'b1);
    // Init pin passes two sync stages before the edge is seen
    repeat (2) @(posedge mclk);
    av(1'b0, `LCDHP_OFS_STATUS, 32'h0);
    chk(rv & 32'h30, 32'h30);
    hc(1'b0, 1'b1, 1'b0, 8'h00);
    chkp(hv & 8'h1F, 8'h10);
    repeat (60) @(posedge mclk);
    av(1'b0, `LCDHP_OFS_CTRL, 32'h0);
    chk(rv, 32'h6);
    suite();
    final_report();
  end
endmodule
